/* File: hdl/trb_pkg.sv */
// Constants and types shared by both ends of the telemetry read-back link.
package trb_pkg;
    localparam logic [7:0] LOC_READBACK_CMD = 8'h80;
    localparam logic [7:0] LOC_TURN_OFF = 8'h0E;
    localparam logic [7:0] SUB_INSTANT_STATUS = 8'h14;
    localparam logic [7:0] SUB_REGION_FLAGS = 8'h16;
    localparam logic [7:0] SUB_AVG_CURRENT = 8'h18;
    localparam logic [7:0] SUB_AVG_VOLTAGE = 8'h1A;
    localparam logic [7:0] SUB_DAC_READBACK = 8'h1C;
    localparam logic [7:0] SUB_FAULT_HISTORY = 8'h20;
    localparam logic [7:0] SUB_INTERRUPT_WORD = 8'h22;
    localparam int BIT_INT_ENABLE = 15;
    localparam int BIT_SYSTEM_READY = 14;
    localparam int BIT_TURN_OFF_CMD = 12;
    localparam int BIT_PSU_OFF_SEEN = 5;
    localparam int BIT_SENSE_SHORT_RESTART = 12;
    localparam int BIT_OVERVOLTAGE_RESTART = 10;
    localparam int BIT_CONSTANT_CURRENT = 2;
    localparam int BIT_CONSTANT_POWER = 1;
    localparam int BIT_CONSTANT_VOLTAGE = 0;
    localparam int INT_STATUS_LSB = 0;
    localparam int INT_MASK_LSB = 9;
    localparam int INT_BITS = 7;
    localparam int INT_NOT_READY = 6;
    localparam int INT_TURN_OFF = 5;
    localparam logic [15:0] LIVE_FLAG_MASK = 16'h363F;
    localparam logic [15:0] FAULT_HISTORY_MASK = 16'h9EF7;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [2:0] RESET_REGION = 3'h1;
    localparam int SAMPLE_COUNT = 16;
    localparam int SAMPLE_SHIFT = 4;
    localparam logic [4:0] HOST_REG_CMD = 5'h00;
    localparam logic [4:0] HOST_REG_DATA = 5'h04;
    localparam logic [4:0] HOST_REG_STAT = 5'h08;
    localparam logic [4:0] HOST_REG_INT_STATUS = 5'h0C;
    localparam logic [4:0] HOST_REG_INT_MASK = 5'h10;
    localparam logic [1:0] OP_READ = 2'h1;
    localparam logic [1:0] OP_TURN_OFF = 2'h2;
    localparam logic [1:0] OP_WRITE_INT = 2'h3;
    typedef enum logic [2:0] {
        ST_POLL_SEL = 3'b000,
        ST_POLL_RD = 3'b001,
        ST_POLL_WAIT = 3'b010,
        ST_IDLE = 3'b011,
        ST_CMD_SEL = 3'b100,
        ST_CMD_RD = 3'b101,
        ST_CMD_WAIT = 3'b110,
        ST_CMD_WR = 3'b111
    } trb_host_state_type;
endpackage

/* File: hdl/trb_link_if.sv */
// Word-level link between the controlling host and the telemetry bank.
`timescale 1ns/1ps
interface trb_link_if;
    logic wr_en;
    logic rd_en;
    logic [7:0] loc;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic rvalid;
    logic restart;
    logic irq;
    modport host_end(output wr_en, rd_en, loc, wdata, input rdata, rvalid, restart, irq);
    modport device_end(input wr_en, rd_en, loc, wdata, output rdata, rvalid, restart, irq);
endinterface

/* File: hdl/trb_averager.sv */
// Running mean over the last sixteen samples of one measurement.
`timescale 1ns/1ps
module trb_averager
    import trb_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] sample,
    input wire logic sample_valid,
    output logic [WIDTH-1:0] mean
);
    logic [WIDTH-1:0] taps [SAMPLE_COUNT];
    logic [WIDTH+SAMPLE_SHIFT-1:0] sum;

    genvar i;
    generate
        for (i = 0; i < SAMPLE_COUNT; i++) begin : g_tap
            always_ff @(posedge ref_clk) begin
                if (srst) begin
                    taps[i] <= '0;
                end else if (sample_valid) begin
                    taps[i] <= (i == 0) ? sample : taps[(i == 0) ? 0 : i - 1];
                end
            end
        end
    endgenerate

    // The sum drops the oldest tap as the newest enters, so it never overflows.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sum <= '0;
        end else if (sample_valid) begin
            sum <= sum + (WIDTH+SAMPLE_SHIFT)'(sample)
                - (WIDTH+SAMPLE_SHIFT)'(taps[SAMPLE_COUNT-1]);
        end
    end

    assign mean = sum[WIDTH+SAMPLE_SHIFT-1:SAMPLE_SHIFT];
endmodule

/* File: hdl/trb_device_end.sv */
// Telemetry read-back register bank at the controller end of the link.
`timescale 1ns/1ps
module trb_device_end
    import trb_pkg::*;
#(
    parameter int CUR_WIDTH = 8,
    parameter int VOLT_WIDTH = 12
) (
    input wire logic ref_clk,
    input wire logic srst,
    trb_link_if.device_end link,
    input wire logic able_in,
    input wire logic [CUR_WIDTH-1:0] current_sample,
    input wire logic current_valid,
    input wire logic [VOLT_WIDTH-1:0] voltage_sample,
    input wire logic voltage_valid,
    input wire logic [15:0] dac_readback,
    input wire logic [15:0] live_flags,
    input wire logic [15:0] fault_events,
    input wire logic [INT_BITS-1:0] int_events,
    input wire logic restart_evt,
    input wire logic [CUR_WIDTH-1:0] cc_setpoint,
    input wire logic [CUR_WIDTH+VOLT_WIDTH-1:0] power_limit,
    output logic [2:0] regulation_region_flags,
    output logic psu_off,
    output logic irq
);
    logic [CUR_WIDTH-1:0] avg_current;
    logic [VOLT_WIDTH-1:0] avg_voltage;
    logic system_ready;
    logic [7:0] selected_sub;
    logic [15:0] instant_status_word;
    logic [15:0] avg_current_word;
    logic [15:0] avg_voltage_word;
    logic [15:0] fault_history_word;
    logic [INT_BITS-1:0] int_status;
    logic [INT_BITS-1:0] int_mask;
    logic [15:0] interrupt_word;
    logic [15:0] next_rdata;
    logic [2:0] next_region;
    logic turn_off_cmd;
    logic int_write;
    logic ready_prev;
    logic [INT_BITS-1:0] int_set;
    logic [CUR_WIDTH+VOLT_WIDTH-1:0] avg_power;

    trb_averager #(.WIDTH(CUR_WIDTH)) u_avg_current (
        .ref_clk(ref_clk),
        .srst(srst),
        .sample(current_sample),
        .sample_valid(current_valid),
        .mean(avg_current)
    );

    trb_averager #(.WIDTH(VOLT_WIDTH)) u_avg_voltage (
        .ref_clk(ref_clk),
        .srst(srst),
        .sample(voltage_sample),
        .sample_valid(voltage_valid),
        .mean(avg_voltage)
    );

    // Ready follows the capability input, but is held low during reset.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            system_ready <= 1'b0;
        end else begin
            system_ready <= able_in;
        end
    end

    // Restart pulse tells the host to poll the ready flag again.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            link.restart <= 1'b0;
        end else begin
            link.restart <= restart_evt;
        end
    end

    // The read-back selection is always accepted, even while not ready.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            selected_sub <= SUB_INSTANT_STATUS;
        end else if (link.wr_en && link.loc == LOC_READBACK_CMD) begin
            selected_sub <= link.wdata[7:0];
        end
    end

    assign turn_off_cmd = link.wr_en && system_ready && link.loc == LOC_TURN_OFF
        && link.wdata[BIT_TURN_OFF_CMD];
    assign int_write = link.wr_en && system_ready && link.loc == SUB_INTERRUPT_WORD;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            psu_off <= 1'b0;
        end else if (turn_off_cmd) begin
            psu_off <= 1'b1;
        end
    end

    // Fault history only clears through reset; events are gathered sticky.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            fault_history_word <= RESET_WORD;
        end else begin
            fault_history_word <= fault_history_word | (fault_events & FAULT_HISTORY_MASK);
            if (fault_events[BIT_SENSE_SHORT_RESTART]) begin
                fault_history_word[BIT_SENSE_SHORT_RESTART] <= 1'b1;
            end
            if (fault_events[BIT_OVERVOLTAGE_RESTART]) begin
                fault_history_word[BIT_OVERVOLTAGE_RESTART] <= 1'b1;
            end
            if (turn_off_cmd) begin
                fault_history_word[BIT_PSU_OFF_SEEN] <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ready_prev <= 1'b0;
        end else begin
            ready_prev <= system_ready;
        end
    end

    always_comb begin
        int_set = int_events;
        int_set[INT_NOT_READY] = ready_prev && !system_ready;
        int_set[INT_TURN_OFF] = int_events[INT_TURN_OFF] | turn_off_cmd;
    end

    // Status bits clear on a written one; a new event in that cycle wins.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            int_status <= '0;
        end else if (int_write) begin
            int_status <= (int_status & ~link.wdata[INT_STATUS_LSB +: INT_BITS]) | int_set;
        end else begin
            int_status <= int_status | int_set;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            int_mask <= '0;
        end else if (int_write) begin
            int_mask <= link.wdata[INT_MASK_LSB +: INT_BITS];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irq <= 1'b0;
            link.irq <= 1'b0;
        end else begin
            irq <= |(int_status & int_mask);
            link.irq <= |(int_status & int_mask);
        end
    end

    always_comb begin
        interrupt_word = RESET_WORD;
        interrupt_word[INT_STATUS_LSB +: INT_BITS] = int_status;
        interrupt_word[INT_MASK_LSB +: INT_BITS] = int_mask;
    end

    always_comb begin
        instant_status_word = live_flags & LIVE_FLAG_MASK;
        instant_status_word[BIT_SYSTEM_READY] = system_ready;
        instant_status_word[BIT_INT_ENABLE] = |int_mask;
    end

    assign avg_current_word = {{(16-CUR_WIDTH){1'b0}}, avg_current};
    assign avg_voltage_word = {{(16-VOLT_WIDTH){1'b0}}, avg_voltage};
    assign avg_power = (CUR_WIDTH+VOLT_WIDTH)'(avg_current) * (CUR_WIDTH+VOLT_WIDTH)'(avg_voltage);

    // Regulation decisions look only at the averaged current and voltage, never a raw sample.
    always_comb begin
        next_region = '0;
        if (avg_current >= cc_setpoint) begin
            next_region[BIT_CONSTANT_CURRENT] = 1'b1;
        end else if (avg_power >= power_limit) begin
            next_region[BIT_CONSTANT_POWER] = 1'b1;
        end else begin
            next_region[BIT_CONSTANT_VOLTAGE] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            regulation_region_flags <= RESET_REGION;
        end else begin
            regulation_region_flags <= next_region;
        end
    end

    always_comb begin
        if (selected_sub == SUB_INSTANT_STATUS) begin
            next_rdata = instant_status_word;
        end else if (selected_sub == SUB_REGION_FLAGS) begin
            next_rdata = {13'h0000, regulation_region_flags};
        end else if (selected_sub == SUB_AVG_CURRENT) begin
            next_rdata = avg_current_word;
        end else if (selected_sub == SUB_AVG_VOLTAGE) begin
            next_rdata = avg_voltage_word;
        end else if (selected_sub == SUB_DAC_READBACK) begin
            next_rdata = dac_readback;
        end else if (selected_sub == SUB_FAULT_HISTORY) begin
            next_rdata = fault_history_word;
        end else if (selected_sub == SUB_INTERRUPT_WORD) begin
            next_rdata = interrupt_word;
        end else begin
            next_rdata = RESET_WORD;
        end
    end

    // Reads of the command location return the selected word one cycle later.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            link.rdata <= RESET_WORD;
            link.rvalid <= 1'b0;
        end else begin
            link.rvalid <= link.rd_en;
            if (link.rd_en && link.loc == LOC_READBACK_CMD) begin
                link.rdata <= next_rdata;
            end else if (link.rd_en) begin
                link.rdata <= RESET_WORD;
            end
        end
    end
endmodule

/* File: hdl/trb_host_end.sv */
// Host end: polls ready, then runs read, turn-off and interrupt-word commands.
`timescale 1ns/1ps
module trb_host_end
    import trb_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    trb_link_if.host_end link,
    input wire logic [4:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    output logic irq
);
    trb_host_state_type state;
    logic [7:0] sub;
    logic [1:0] op;
    logic [15:0] data;
    logic [1:0] int_status;
    logic [1:0] int_mask;
    logic go;
    logic read_done;

    assign go = wr && addr == HOST_REG_CMD && state == ST_IDLE && wdata[9:8] != 2'h0;
    assign read_done = state == ST_CMD_WAIT && link.rvalid;

    // Link strobes come straight from this state machine's registers.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state <= ST_POLL_SEL;
            link.wr_en <= 1'b0;
            link.rd_en <= 1'b0;
            link.loc <= 8'h00;
            link.wdata <= RESET_WORD;
        end else begin
            link.wr_en <= 1'b0;
            link.rd_en <= 1'b0;
            if (link.restart) begin
                state <= ST_POLL_SEL;
            end else begin
                case (state)
                    ST_POLL_SEL: begin
                        link.wr_en <= 1'b1;
                        link.loc <= LOC_READBACK_CMD;
                        link.wdata <= {8'h00, SUB_INSTANT_STATUS};
                        state <= ST_POLL_RD;
                    end
                    ST_POLL_RD: begin
                        link.rd_en <= 1'b1;
                        link.loc <= LOC_READBACK_CMD;
                        state <= ST_POLL_WAIT;
                    end
                    ST_POLL_WAIT: begin
                        if (link.rvalid) begin
                            state <= link.rdata[BIT_SYSTEM_READY] ? ST_IDLE : ST_POLL_SEL;
                        end
                    end
                    ST_IDLE: begin
                        if (go) begin
                            state <= (wdata[9:8] == OP_READ) ? ST_CMD_SEL : ST_CMD_WR;
                        end
                    end
                    ST_CMD_SEL: begin
                        link.wr_en <= 1'b1;
                        link.loc <= LOC_READBACK_CMD;
                        link.wdata <= {8'h00, sub};
                        state <= ST_CMD_RD;
                    end
                    ST_CMD_RD: begin
                        link.rd_en <= 1'b1;
                        link.loc <= LOC_READBACK_CMD;
                        state <= ST_CMD_WAIT;
                    end
                    ST_CMD_WAIT: begin
                        if (link.rvalid) begin
                            state <= ST_IDLE;
                        end
                    end
                    ST_CMD_WR: begin
                        link.wr_en <= 1'b1;
                        link.loc <= (op == OP_TURN_OFF) ? LOC_TURN_OFF : SUB_INTERRUPT_WORD;
                        link.wdata <= data;
                        state <= ST_IDLE;
                    end
                    default: state <= ST_POLL_SEL;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sub <= 8'h00;
            op <= 2'h0;
        end else if (go) begin
            sub <= wdata[7:0];
            op <= wdata[9:8];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            data <= RESET_WORD;
        end else if (read_done) begin
            data <= link.rdata;
        end else if (wr && addr == HOST_REG_DATA) begin
            data <= wdata;
        end
    end

    // Bit 0 marks a finished read, bit 1 a controller restart; set beats clear.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            int_status <= 2'h0;
            int_mask <= 2'h0;
        end else begin
            int_status <= (int_status & ~((wr && addr == HOST_REG_INT_STATUS) ? wdata[1:0] : 2'h0))
                | {link.restart, read_done};
            if (wr && addr == HOST_REG_INT_MASK) begin
                int_mask <= wdata[1:0];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irq <= 1'b0;
            rdata <= RESET_WORD;
        end else begin
            irq <= |(int_status & int_mask);
            if (!rd) begin
                rdata <= RESET_WORD;
            end else if (addr == HOST_REG_CMD) begin
                rdata <= {6'h00, op, sub};
            end else if (addr == HOST_REG_DATA) begin
                rdata <= data;
            end else if (addr == HOST_REG_STAT) begin
                rdata <= {13'h0000, link.irq, state != ST_IDLE,
                    state[2] || state == ST_IDLE};
            end else if (addr == HOST_REG_INT_STATUS) begin
                rdata <= {14'h0000, int_status};
            end else if (addr == HOST_REG_INT_MASK) begin
                rdata <= {14'h0000, int_mask};
            end else begin
                rdata <= RESET_WORD;
            end
        end
    end
endmodule

/* File: test/trb_link_props.sv */
// Concurrent checks on the link between the host end and the telemetry bank.
`timescale 1ns/1ps
module trb_link_props
    import trb_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] loc,
    input wire logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic rvalid,
    input wire logic restart,
    input wire logic irq
);
    logic [7:0] sel;
    logic [7:0] rd_sel;
    logic [6:0] mask;
    logic ready_seen;
    logic off_seen;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    // Shadow of the read-back selection, captured per read.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sel <= SUB_INSTANT_STATUS;
        end else if (wr_en && loc == LOC_READBACK_CMD) begin
            sel <= wdata[7:0];
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rd_en) begin
            rd_sel <= sel;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mask <= 7'h00;
        end else if (wr_en && loc == SUB_INTERRUPT_WORD) begin
            mask <= wdata[15:9];
        end
    end
    // Ready is known to the host only after a status read showing it.
    always_ff @(posedge ref_clk) begin
        if (srst || restart) begin
            ready_seen <= 1'b0;
        end else if (rvalid && rd_sel == SUB_INSTANT_STATUS && rdata[BIT_SYSTEM_READY]) begin
            ready_seen <= 1'b1;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            off_seen <= 1'b0;
        end else if (wr_en && loc == LOC_TURN_OFF && wdata[BIT_TURN_OFF_CMD] && ready_seen) begin
            off_seen <= 1'b1;
        end
    end
    a_read_answer: assert property (rd_en |=> rvalid)
        else $error("read not answered in the next cycle");
    a_answer_cause: assert property (rvalid |-> $past(rd_en))
        else $error("read answer without a read");
    a_status_zero: assert property ((rvalid && rd_sel == SUB_INSTANT_STATUS) |->
        (rdata & 16'h09C0) == 16'h0000) else $error("unused status bits set");
    a_cur_high_zero: assert property ((rvalid && rd_sel == SUB_AVG_CURRENT) |->
        rdata[15:8] == 8'h00) else $error("current mean upper byte not zero");
    a_volt_high_zero: assert property ((rvalid && rd_sel == SUB_AVG_VOLTAGE) |->
        rdata[15:12] == 4'h0) else $error("voltage mean upper bits not zero");
    a_region_onehot: assert property ((rvalid && rd_sel == SUB_REGION_FLAGS) |->
        $onehot(rdata[2:0]) && rdata[15:3] == 13'h0000) else $error("region flags not one-hot");
    a_turnoff_logged: assert property ((rvalid && rd_sel == SUB_FAULT_HISTORY && off_seen) |->
        rdata[BIT_PSU_OFF_SEEN]) else $error("turn-off not logged in fault history");
    a_irq_masked: assert property ((mask == 7'h00 && $past(mask) == 7'h00) |-> !irq)
        else $error("interrupt raised with all sources masked");
    a_repoll_restart: assert property (restart |-> ##[1:4] (wr_en && loc == LOC_READBACK_CMD
        && wdata[7:0] == SUB_INSTANT_STATUS)) else $error("no status poll after restart");
    a_cmd_after_ready: assert property ((wr_en && loc != LOC_READBACK_CMD) |-> ready_seen)
        else $error("command issued before ready was seen");
endmodule

/* File: test/telemetry_readback_regs_tb.sv */
// Self-checking bench joining the host end and the telemetry bank.
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_total++; \
    $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end
module telemetry_readback_regs_tb import trb_pkg::*; ;
    logic ref_clk = 1'b0;
    logic srst, wr, rd, able_in, cur_v, volt_v, restart_evt, psu_off, dev_irq, host_irq;
    logic [4:0] addr;
    logic [15:0] wdata, rdata, dac, live, faults, r;
    logic [7:0] cur, cc_sp, mean_i;
    logic [11:0] volt, mean_v;
    logic [6:0] int_ev;
    logic [19:0] p_lim;
    logic [2:0] region;
    logic [31:0] seed = 32'h00000060;
    logic [31:0] v;
    int err_total = 0;
    int n_checks = 0;
    int sum_i, sum_v;
    trb_link_if link();
    trb_host_end i_trb_host_end (.ref_clk(ref_clk), .srst(srst), .link(link), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(host_irq));
    trb_device_end i_trb_device_end (.ref_clk(ref_clk), .srst(srst), .link(link),
        .able_in(able_in), .current_sample(cur), .current_valid(cur_v), .voltage_sample(volt),
        .voltage_valid(volt_v), .dac_readback(dac), .live_flags(live), .fault_events(faults),
        .int_events(int_ev), .restart_evt(restart_evt), .cc_setpoint(cc_sp),
        .power_limit(p_lim), .regulation_region_flags(region), .psu_off(psu_off),
        .irq(dev_irq));
    trb_link_props i_trb_link_props (.ref_clk(ref_clk), .srst(srst), .wr_en(link.wr_en),
        .rd_en(link.rd_en), .loc(link.loc), .wdata(link.wdata), .rdata(link.rdata),
        .rvalid(link.rvalid), .restart(link.restart), .irq(link.irq));
    always #12.5 ref_clk = ~ref_clk;
    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function logic [2:0] region_exp(input logic [7:0] ai, input logic [11:0] av,
        input logic [7:0] sp, input logic [19:0] lim);
        if (ai >= sp) return 3'b100;
        if (20'(ai) * 20'(av) >= lim) return 3'b010;
        return 3'b001;
    endfunction
    task final_report();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task sw_write(input logic [4:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    task sw_read(input logic [4:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        @(negedge ref_clk);
        d = rdata;
    endtask
    task wait_stat(input int b, input logic val);
        logic [15:0] s;
        for (int i = 0; i < 300; i++) begin
            sw_read(HOST_REG_STAT, s);
            if (s[b] === val) return;
        end
        err_total++;
        $display("mismatch at %0t: wait ran out", $time);
        final_report();
    endtask
    task run_cmd(input logic [1:0] op, input logic [7:0] sub, input logic [15:0] d,
        output logic [15:0] res);
        sw_write(HOST_REG_DATA, d);
        sw_write(HOST_REG_CMD, {6'h00, op, sub});
        wait_stat(1, 1'b0);
        sw_read(HOST_REG_DATA, res);
    endtask
    task settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task pulse_int(input logic [6:0] e);
        @(posedge ref_clk);
        int_ev <= e;
        @(posedge ref_clk);
        int_ev <= 7'h00;
        settle(3);
    endtask
    initial begin
        {srst, wr, rd, able_in, cur_v, volt_v, restart_evt} = 7'h40;
        {addr, wdata, dac, live, faults, int_ev, cur, volt} = '0;
        cc_sp = 8'hFF;
        p_lim = 20'hFFFFF;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        repeat (20) @(posedge ref_clk);
        sw_read(HOST_REG_STAT, r);
        `CHK(r[0], 1'b0)
        @(posedge ref_clk);
        able_in <= 1'b1;
        wait_stat(0, 1'b1);
        sum_i = 0;
        sum_v = 0;
        for (int i = 0; i < SAMPLE_COUNT; i++) begin
            v = xs();
            @(posedge ref_clk);
            cur <= v[7:0];
            volt <= v[19:8];
            cur_v <= 1'b1;
            volt_v <= 1'b1;
            sum_i += int'(v[7:0]);
            sum_v += int'(v[19:8]);
        end
        @(posedge ref_clk);
        cur_v <= 1'b0;
        volt_v <= 1'b0;
        mean_i = 8'(sum_i / SAMPLE_COUNT);
        mean_v = 12'(sum_v / SAMPLE_COUNT);
        run_cmd(OP_READ, SUB_AVG_CURRENT, 16'h0000, r);
        `CHK(r, {8'h00, mean_i})
        run_cmd(OP_READ, SUB_AVG_VOLTAGE, 16'h0000, r);
        `CHK(r, {4'h0, mean_v})
        // Threshold equal to the mean, then just above it with low and high power limits.
        for (int k = 0; k < 3; k++) begin
            @(posedge ref_clk);
            cc_sp <= mean_i + 8'(k != 0);
            p_lim <= (k == 1) ? 20'h00000 : 20'hFFFFF;
            settle(3);
            `CHK(region, region_exp(mean_i, mean_v, cc_sp, p_lim))
            run_cmd(OP_READ, SUB_REGION_FLAGS, 16'h0000, r);
            `CHK(r, {13'h0000, region_exp(mean_i, mean_v, cc_sp, p_lim)})
        end
        v = xs();
        @(posedge ref_clk);
        dac <= v[15:0];
        live <= v[31:16];
        run_cmd(OP_READ, SUB_INSTANT_STATUS, 16'h0000, r);
        `CHK(r, (live & LIVE_FLAG_MASK) | 16'h4000)
        run_cmd(OP_READ, SUB_DAC_READBACK, 16'h0000, r);
        `CHK(r, dac)
        @(posedge ref_clk);
        faults <= 16'h1400;
        @(posedge ref_clk);
        faults <= 16'h0000;
        run_cmd(OP_READ, SUB_FAULT_HISTORY, 16'h0000, r);
        `CHK(r, 16'h1400)
        run_cmd(OP_TURN_OFF, 8'h00, 16'h1000, r);
        `CHK(psu_off, 1'b1)
        run_cmd(OP_READ, SUB_FAULT_HISTORY, 16'h0000, r);
        `CHK(r, 16'h1420)
        sw_write(5'h1C, 16'hFFFF);
        run_cmd(OP_WRITE_INT, 8'h00, 16'h0200, r);
        run_cmd(OP_READ, SUB_INTERRUPT_WORD, 16'h0000, r);
        `CHK(r, 16'h0220)
        settle(3);
        `CHK(dev_irq, 1'b0)
        pulse_int(7'h01);
        `CHK(dev_irq, 1'b1)
        sw_read(HOST_REG_STAT, r);
        `CHK(r[2], 1'b1)
        run_cmd(OP_READ, SUB_INSTANT_STATUS, 16'h0000, r);
        `CHK(r, (live & LIVE_FLAG_MASK) | 16'hC000)
        run_cmd(OP_WRITE_INT, 8'h00, 16'h0201, r);
        settle(3);
        `CHK(dev_irq, 1'b0)
        pulse_int(7'h02);
        `CHK(dev_irq, 1'b0)
        sw_write(HOST_REG_INT_MASK, 16'h0001);
        settle(2);
        `CHK(host_irq, 1'b1)
        sw_write(HOST_REG_INT_STATUS, 16'h0001);
        settle(2);
        `CHK(host_irq, 1'b0)
        @(posedge ref_clk);
        restart_evt <= 1'b1;
        @(posedge ref_clk);
        restart_evt <= 1'b0;
        settle(2);
        sw_read(HOST_REG_INT_STATUS, r);
        `CHK(r[1], 1'b1)
        wait_stat(0, 1'b1);
        final_report();
    end
endmodule
